/* File: inc/bcd_arith_pkg.sv */
// Shared constants and types for the decimal mantissa datapath.
// Assumes a single 200 MHz core clock and a synchronous active-high reset.
package bcd_arith_pkg;

    // Geometry of a mantissa: twelve BCD digits in three 16-bit words.
    localparam int DIGITS = 12;
    localparam int DIGIT_W = 4;
    localparam int MANT_W = DIGITS * DIGIT_W;
    localparam int WORD_W = 16;
    localparam int WORDS = 3;

    // Largest digit value and the decimal correction added above it.
    localparam logic [4:0] DIGIT_MAX = 5'h09;
    localparam logic [4:0] DECIMAL_FIX = 5'h06;
    localparam logic [3:0] NINE = 4'h9;

    // Normalize gives up after this many left shifts.
    localparam logic [3:0] NRM_MAX = 4'hc;

    // Right shifts beyond this count cannot change the outcome.
    localparam logic [15:0] SHIFT_CLAMP = 16'h000e;

    // Word select values for the word access port.
    localparam logic WORD_SEL_OPERAND = 1'b0;
    localparam logic WORD_SEL_RESULT = 1'b1;

    // Operations issued by the processor core.
    typedef enum logic [3:0] {
        OP_OPERAND_RSHIFT,
        OP_RESULT_RSHIFT,
        OP_MANTISSA_ADD,
        OP_NORMALIZE,
        OP_ADD_B,
        OP_FAST_MULTIPLY,
        OP_COMPLEMENT_OPERAND,
        OP_COMPLEMENT_RESULT,
        OP_CLEAR_CARRY
    } op_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RSHIFT,
        ST_NORMALIZE,
        ST_MULTIPLY
    } state_t;

endpackage

/* File: hw/bcd_mantissa_adder.sv */
// Twelve-digit BCD ripple adder, purely combinational.
// Assumes both operands hold valid BCD digits.
`timescale 1ns/100ps
module bcd_mantissa_adder
    import bcd_arith_pkg::*;
(
    input wire logic [MANT_W-1:0] augend,
    input wire logic [MANT_W-1:0] addend,
    input wire logic carry_in,
    output logic [MANT_W-1:0] sum,
    output logic carry_out
);

    // Carry chain between digits; entry 0 is the least significant input.
    logic [DIGITS:0] chain;

    assign chain[0] = carry_in;

    // One decimal digit stage per position, least significant first.
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : digit_stage
            logic [4:0] raw;
            logic [4:0] fixed;
            // Binary sum of the two digits and the incoming carry.
            assign raw = {1'b0, augend[g*DIGIT_W +: DIGIT_W]}
                       + {1'b0, addend[g*DIGIT_W +: DIGIT_W]}
                       + {4'h0, chain[g]};
            // Above nine the digit wraps by adding six and a carry leaves.
            assign fixed = (raw > DIGIT_MAX) ? (raw + DECIMAL_FIX) : raw;
            assign sum[g*DIGIT_W +: DIGIT_W] = fixed[3:0];
            assign chain[g+1] = raw > DIGIT_MAX;
        end
    endgenerate

    assign carry_out = chain[DIGITS];

endmodule

/* File: hw/bcd_mantissa_arith_unit.sv */
// Decimal mantissa datapath: shifts, adds, normalize, multiply, complements.
// Assumes the processor core drives requests on core_clk and owns A and B.
//
// Overview of operation
// - Right shifts of either mantissa by B count.
// - First shift inserts A nibble, later zeros.
// - Last digit shifted out returns in A.
// - Both right shifts clear the decimal carry.
// - Add operand into accumulator as unsigned decimal.
// - Carry flag feeds in, takes carry out.
// - Normalize shifts accumulator left until leading nonzero.
// - Normalize returns its shift count in B.
// - At most twelve shifts; twelve sets carry.
// - Other normalize counts leave carry cleared.
// - Add B into accumulator; takes carry out, carry flag does not feed in.
// - Fast multiply adds operand B-low-nibble times.
// - Multiply overflow digit returned in A.
// - Complements clear carry; zero stays zero.
`timescale 1ns/100ps
module bcd_mantissa_arith_unit
    import bcd_arith_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic op_start,
    input wire op_t op_code,
    input wire logic [WORD_W-1:0] a_in,
    input wire logic [WORD_W-1:0] b_in,
    output logic busy,
    output logic op_done,
    output logic [DIGIT_W-1:0] a_out,
    output logic a_write,
    output logic [WORD_W-1:0] b_out,
    output logic b_write,
    output logic decimal_carry_flag,
    input wire logic word_write,
    input wire logic word_sel,
    input wire logic [1:0] word_index,
    input wire logic [WORD_W-1:0] word_wdata,
    output logic [WORD_W-1:0] word_rdata
);

    // The two mantissas; the most significant digit sits in the top nibble.
    logic [MANT_W-1:0] operand_mantissa;
    logic [MANT_W-1:0] result_accumulator;

    // Sequencer state and the operation being worked on.
    state_t state;
    logic shift_operand;

    // Remaining right shifts or remaining multiply adds.
    logic [15:0] steps_left;
    // True until the first right shift of an operation has happened.
    logic first_shift;
    // Nibble that the first right shift brings in.
    logic [DIGIT_W-1:0] fill_nibble;
    // Last digit pushed off the low end during a right shift.
    logic [DIGIT_W-1:0] lost_digit;
    // Left shifts done so far by normalize.
    logic [3:0] nrm_count;
    // Overflow digit built up by fast multiply.
    logic [DIGIT_W-1:0] ov_digit;

    // Adder hookup.
    logic [MANT_W-1:0] add_addend;
    logic [MANT_W-1:0] add_augend;
    logic add_cin;
    logic [MANT_W-1:0] add_sum;
    logic add_cout;
    // Nines complement of the mantissa that a complement op names.
    logic [MANT_W-1:0] nines;

    // The requester may only start an operation while idle.
    assign busy = state != ST_IDLE;

    // Digit-by-digit nines complement of the selected mantissa.
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : nines_digit
            assign nines[g*DIGIT_W +: DIGIT_W] = NINE - (op_code == OP_COMPLEMENT_OPERAND ?
                operand_mantissa[g*DIGIT_W +: DIGIT_W] :
                result_accumulator[g*DIGIT_W +: DIGIT_W]);
        end
    endgenerate

    // Chooses what the adder sums for the current operation.
    always_comb begin
        add_augend = result_accumulator;
        add_addend = operand_mantissa;
        add_cin = 1'b0;
        if (state == ST_IDLE) begin
            unique case (op_code)
                OP_MANTISSA_ADD: begin
                    // Carry flag enters at the lowest digit.
                    add_cin = decimal_carry_flag;
                end
                OP_ADD_B: begin
                    // B is taken as four packed digits at the low end.
                    add_addend = {{(MANT_W-WORD_W){1'b0}}, b_in};
                end
                OP_COMPLEMENT_OPERAND, OP_COMPLEMENT_RESULT: begin
                    // Ten's complement is nines complement plus one.
                    add_augend = nines;
                    add_addend = '0;
                    add_cin = 1'b1;
                end
                default: begin
                    add_cin = 1'b0;
                end
            endcase
        end
    end

    // Shared decimal adder.
    bcd_mantissa_adder adder (
        .augend(add_augend),
        .addend(add_addend),
        .carry_in(add_cin),
        .sum(add_sum),
        .carry_out(add_cout)
    );

    // Sequencer: picks the state that follows each operation step.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (op_start) begin
                        unique case (op_code)
                            OP_OPERAND_RSHIFT, OP_RESULT_RSHIFT: begin
                                state <= ST_RSHIFT;
                            end
                            OP_NORMALIZE: begin
                                state <= ST_NORMALIZE;
                            end
                            OP_FAST_MULTIPLY: begin
                                state <= ST_MULTIPLY;
                            end
                            default: begin
                                state <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_RSHIFT, ST_MULTIPLY: begin
                    // Finish when the step counter runs out.
                    if (steps_left == '0) begin
                        state <= ST_IDLE;
                    end
                end
                ST_NORMALIZE: begin
                    // Stop on a nonzero leading digit or after twelve shifts.
                    if (result_accumulator[MANT_W-1 -: DIGIT_W] != '0 || nrm_count == NRM_MAX) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Step counters and the values latched at the start of an operation.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            steps_left <= '0;
            first_shift <= 1'b0;
            fill_nibble <= '0;
            shift_operand <= 1'b0;
            nrm_count <= '0;
        end else if (state == ST_IDLE && op_start) begin
            // Shift count comes from B, clamped where more shifts change nothing.
            if (op_code == OP_FAST_MULTIPLY) begin
                // Only the low nibble of B counts the adds.
                steps_left <= {12'h000, b_in[DIGIT_W-1:0]};
            end else begin
                steps_left <= (b_in > SHIFT_CLAMP) ? SHIFT_CLAMP : b_in;
            end
            first_shift <= 1'b1;
            fill_nibble <= a_in[DIGIT_W-1:0];
            shift_operand <= op_code == OP_OPERAND_RSHIFT;
            nrm_count <= '0;
        end else if ((state == ST_RSHIFT || state == ST_MULTIPLY) && steps_left != '0) begin
            steps_left <= steps_left - 16'h0001;
            first_shift <= 1'b0;
        end else if (state == ST_NORMALIZE) begin
            if (result_accumulator[MANT_W-1 -: DIGIT_W] == '0 && nrm_count != NRM_MAX) begin
                nrm_count <= nrm_count + 4'h1;
            end
        end
    end

    // Operand mantissa: word writes, right shifts and complement.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            operand_mantissa <= '0;
        end else if (state == ST_IDLE) begin
            if (op_start && op_code == OP_COMPLEMENT_OPERAND) begin
                // Zero complements to zero since the carry out is dropped.
                operand_mantissa <= add_sum;
            end else if (word_write && word_sel == WORD_SEL_OPERAND) begin
                // Word 0 holds the leading digits, word 2 the lowest.
                operand_mantissa[MANT_W-1-word_index*WORD_W -: WORD_W] <= word_wdata;
            end
        end else if (state == ST_RSHIFT && shift_operand && steps_left != '0) begin
            // First shift brings in the A nibble, later ones zero.
            operand_mantissa <= {first_shift ? fill_nibble : 4'h0,
                operand_mantissa[MANT_W-1:DIGIT_W]};
        end
    end

    // Result accumulator: word writes, shifts, adds and complement.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            result_accumulator <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (op_start && (op_code == OP_MANTISSA_ADD || op_code == OP_ADD_B ||
                        op_code == OP_COMPLEMENT_RESULT)) begin
                        // Unsigned decimal sum lands in the accumulator.
                        result_accumulator <= add_sum;
                    end else if (!op_start && word_write && word_sel == WORD_SEL_RESULT) begin
                        result_accumulator[MANT_W-1-word_index*WORD_W -: WORD_W] <= word_wdata;
                    end
                end
                ST_RSHIFT: begin
                    if (!shift_operand && steps_left != '0) begin
                        result_accumulator <= {first_shift ? fill_nibble : 4'h0,
                            result_accumulator[MANT_W-1:DIGIT_W]};
                    end
                end
                ST_NORMALIZE: begin
                    if (result_accumulator[MANT_W-1 -: DIGIT_W] == '0 && nrm_count != NRM_MAX) begin
                        // One digit left per cycle, zero enters at the bottom.
                        result_accumulator <= {result_accumulator[MANT_W-DIGIT_W-1:0], 4'h0};
                    end
                end
                ST_MULTIPLY: begin
                    if (steps_left != '0) begin
                        // Each step adds the operand once more.
                        result_accumulator <= add_sum;
                    end
                end
            endcase
        end
    end

    // Digit lost off the bottom of a right shift and the multiply overflow.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lost_digit <= '0;
            ov_digit <= '0;
        end else if (state == ST_IDLE && op_start) begin
            lost_digit <= '0;
            ov_digit <= '0;
        end else if (state == ST_RSHIFT && steps_left != '0) begin
            // Only the most recent digit shifted out is kept.
            lost_digit <= shift_operand ? operand_mantissa[DIGIT_W-1:0] :
                result_accumulator[DIGIT_W-1:0];
        end else if (state == ST_MULTIPLY && steps_left != '0 && add_cout) begin
            // Every carry past the top digit bumps the overflow digit.
            ov_digit <= ov_digit + 4'h1;
        end
    end

    // Decimal carry flag.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            decimal_carry_flag <= 1'b0;
        end else if (state == ST_IDLE && op_start) begin
            unique case (op_code)
                OP_OPERAND_RSHIFT, OP_RESULT_RSHIFT: begin
                    decimal_carry_flag <= 1'b0;
                end
                OP_MANTISSA_ADD, OP_ADD_B: begin
                    decimal_carry_flag <= add_cout;
                end
                OP_COMPLEMENT_OPERAND, OP_COMPLEMENT_RESULT, OP_CLEAR_CARRY: begin
                    decimal_carry_flag <= 1'b0;
                end
                OP_NORMALIZE: begin
                    decimal_carry_flag <= 1'b0;
                end
                default: begin
                    decimal_carry_flag <= decimal_carry_flag;
                end
            endcase
        end else if (state == ST_NORMALIZE && nrm_count == NRM_MAX) begin
            // A zero mantissa takes all twelve shifts and sets the flag.
            decimal_carry_flag <= 1'b1;
        end
    end

    // Completion strobes and the values handed back to the core's A and B.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            op_done <= 1'b0;
            a_write <= 1'b0;
            a_out <= '0;
            b_write <= 1'b0;
            b_out <= '0;
        end else begin
            op_done <= 1'b0;
            a_write <= 1'b0;
            b_write <= 1'b0;
            if (state == ST_IDLE && op_start) begin
                // Single-cycle operations complete here.
                op_done <= op_code != OP_OPERAND_RSHIFT && op_code != OP_RESULT_RSHIFT &&
                    op_code != OP_NORMALIZE && op_code != OP_FAST_MULTIPLY;
            end else if (state == ST_RSHIFT && steps_left == '0) begin
                op_done <= 1'b1;
                // A is rewritten only if at least one digit was shifted out.
                a_write <= !first_shift;
                a_out <= lost_digit;
            end else if (state == ST_MULTIPLY && steps_left == '0) begin
                op_done <= 1'b1;
                a_write <= 1'b1;
                a_out <= ov_digit;
            end else if (state == ST_NORMALIZE && (nrm_count == NRM_MAX ||
                result_accumulator[MANT_W-1 -: DIGIT_W] != '0)) begin
                op_done <= 1'b1;
                b_write <= 1'b1;
                // Shift count goes back to B as a plain binary number.
                b_out <= {12'h000, nrm_count};
            end
        end
    end

    // Registered read of one mantissa word.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            word_rdata <= '0;
        end else if (word_sel == WORD_SEL_OPERAND) begin
            word_rdata <= operand_mantissa[MANT_W-1-word_index*WORD_W -: WORD_W];
        end else begin
            word_rdata <= result_accumulator[MANT_W-1-word_index*WORD_W -: WORD_W];
        end
    end

endmodule

/* File: test/bcd_arith_checker.sv */
// Port checker for the decimal mantissa datapath.
// Assumes it is bound to the datapath and shares its single clock.
`timescale 1ns/100ps
module bcd_arith_checker
    import bcd_arith_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic op_start,
    input wire op_t op_code,
    input wire logic [WORD_W-1:0] b_in,
    input wire logic busy,
    input wire logic op_done,
    input wire logic [DIGIT_W-1:0] a_out,
    input wire logic a_write,
    input wire logic [WORD_W-1:0] b_out,
    input wire logic b_write,
    input wire logic decimal_carry_flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // A request counts only when it arrives while idle.
    logic take;
    assign take = op_start && !busy;
    // A taken right shift of either mantissa.
    sequence s_rsh;
        take && (op_code == OP_OPERAND_RSHIFT || op_code == OP_RESULT_RSHIFT);
    endsequence
    // Two shift cycles and the closing cycle, then the answer with the saved digit.
    sequence s_two_steps;
        busy [*3] ##1 (op_done && a_write && !busy);
    endsequence
    a_shift_clear: assert property (s_rsh |=> !decimal_carry_flag)
        else $error("right shift left the carry set");
    a_shift_two: assert property (s_rsh ##0 (b_in == 16'h0002) |=> s_two_steps)
        else $error("two digit shift took the wrong time");
    a_shift_none: assert property (s_rsh ##0 (b_in == 16'h0000) |=> ##1 (op_done && !a_write))
        else $error("zero count shift misbehaved");
    a_add_once: assert property (take && op_code == OP_MANTISSA_ADD |=> op_done && !busy)
        else $error("mantissa add did not finish in one cycle");
    a_norm_max: assert property (b_write && b_out == 16'h000c |-> decimal_carry_flag)
        else $error("full normalize left carry clear");
    a_norm_clear: assert property (b_write && b_out != 16'h000c |-> !decimal_carry_flag)
        else $error("partial normalize left carry set");
    a_norm_bound: assert property (b_write |-> b_out <= 16'h000c && op_done)
        else $error("normalize count out of range");
    a_cmp_clear: assert property (take && (op_code == OP_COMPLEMENT_OPERAND ||
        op_code == OP_COMPLEMENT_RESULT) |=> op_done && !decimal_carry_flag)
        else $error("complement left carry set");
    a_mul_zero: assert property (take && op_code == OP_FAST_MULTIPLY && b_in[3:0] == 4'h0
        |=> ##1 (op_done && a_write && a_out == 4'h0))
        else $error("zero count multiply misbehaved");
    a_write_done: assert property (a_write |-> op_done)
        else $error("nibble returned outside an answer");
endmodule

/* File: test/core_model.sv */
// Processor core model that issues operations and keeps its A and B registers.
// Assumes every operation answers with op_done within forty cycles.
`timescale 1ns/100ps
module core_model
    import bcd_arith_pkg::*;
(
    input wire logic core_clk,
    output logic op_start,
    output op_t op_code,
    output logic [WORD_W-1:0] a_in,
    output logic [WORD_W-1:0] b_in,
    input wire logic op_done,
    input wire logic [DIGIT_W-1:0] a_out,
    input wire logic a_write,
    input wire logic [WORD_W-1:0] b_out,
    input wire logic b_write
);
    // The A and B registers are always visible to the datapath.
    logic [WORD_W-1:0] reg_a = 16'h0000;
    logic [WORD_W-1:0] reg_b = 16'h0000;
    assign a_in = reg_a;
    assign b_in = reg_b;
    initial begin
        op_start = 1'b0;
        op_code = OP_CLEAR_CARRY;
    end
    // Load A and B, strobe one request, then wait for the answer.
    task automatic issue(input op_t op, input logic [15:0] a, input logic [15:0] b);
        int n;
        @(negedge core_clk);
        reg_a = a;
        reg_b = b;
        op_code = op;
        op_start = 1'b1;
        @(negedge core_clk);
        op_start = 1'b0;
        n = 0;
        while (op_done !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        // Take back the returned nibble and count in the answer cycle.
        if (a_write === 1'b1) begin
            reg_a[3:0] = a_out;
        end
        if (b_write === 1'b1) begin
            reg_b = b_out;
        end
    endtask
endmodule

/* File: test/bcd_mantissa_arith_unit_tb.sv */
// Self-checking bench for the decimal mantissa datapath.
// Assumes the core model issues operations while the bench owns the word port.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module bcd_mantissa_arith_unit_tb
    import bcd_arith_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic op_start, busy, op_done, a_write, b_write, decimal_carry_flag;
    op_t op_code;
    logic [WORD_W-1:0] a_in, b_in, b_out, word_wdata, word_rdata;
    logic [DIGIT_W-1:0] a_out;
    logic word_write = 1'b0;
    logic word_sel = 1'b0;
    logic [1:0] word_index = 2'h0;
    int err_total = 0;
    int num_checks = 0;
    initial word_wdata = 16'h0000;
    always #2.5 core_clk = ~core_clk;
    bcd_mantissa_arith_unit dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .op_start(op_start), .op_code(op_code), .a_in(a_in), .b_in(b_in), .busy(busy),
        .op_done(op_done), .a_out(a_out), .a_write(a_write), .b_out(b_out),
        .b_write(b_write), .decimal_carry_flag(decimal_carry_flag),
        .word_write(word_write), .word_sel(word_sel), .word_index(word_index),
        .word_wdata(word_wdata), .word_rdata(word_rdata));
    core_model core_u (.core_clk(core_clk), .op_start(op_start), .op_code(op_code),
        .a_in(a_in), .b_in(b_in), .op_done(op_done), .a_out(a_out), .a_write(a_write),
        .b_out(b_out), .b_write(b_write));
    // Reference decimal adder: returns carry and twelve digit sum.
    function automatic logic [48:0] bcd_add(input logic [47:0] x, input logic [47:0] y,
        input logic c);
        logic [4:0] s;
        logic [47:0] r;
        for (int i = 0; i < 12; i++) begin
            s = x[i*4+:4] + y[i*4+:4] + c;
            c = (s > 5'h09);
            s = c ? s - 5'h0a : s;
            r[i*4+:4] = s[3:0];
        end
        return {c, r};
    endfunction
    // Writes a mantissa as three words, most significant first.
    task automatic wr_mant(input logic sel, input logic [47:0] m);
        for (int i = 0; i < 3; i++) begin
            @(negedge core_clk);
            word_write = 1'b1;
            word_sel = sel;
            word_index = i[1:0];
            word_wdata = m[47-16*i-:16];
        end
        @(negedge core_clk);
        word_write = 1'b0;
    endtask
    // Reads a mantissa back and compares it.
    task automatic chk_m(input logic sel, input logic [47:0] ex, input string nm);
        logic [47:0] m;
        for (int i = 0; i < 3; i++) begin
            @(negedge core_clk);
            word_sel = sel;
            word_index = i[1:0];
            @(negedge core_clk);
            m[47-16*i-:16] = word_rdata;
        end
        `CHK(nm, ex, m)
    endtask
    task automatic t_add;
        logic [48:0] e;
        wr_mant(1'b0, 48'h000000000001);
        wr_mant(1'b1, 48'h999999999999);
        core_u.issue(OP_MANTISSA_ADD, 16'h0000, 16'h0000);
        chk_m(1'b1, 48'h000000000000, "sum");
        `CHK("carry", 1'b1, decimal_carry_flag)
        wr_mant(1'b1, 48'h123456789012);
        e = bcd_add(48'h123456789012, 48'h000000000001, 1'b1);
        core_u.issue(OP_MANTISSA_ADD, 16'h0000, 16'h0000);
        chk_m(1'b1, e[47:0], "sum_cin");
        `CHK("carry", e[48], decimal_carry_flag)
        $display("test add done");
    endtask
    task automatic t_addb;
        wr_mant(1'b1, 48'h000000000099);
        core_u.issue(OP_ADD_B, 16'h0000, 16'h0023);
        chk_m(1'b1, 48'h000000000122, "addb");
        wr_mant(1'b1, 48'h999999999999);
        core_u.issue(OP_ADD_B, 16'h0000, 16'h0001);
        chk_m(1'b1, 48'h000000000000, "round");
        `CHK("carry", 1'b1, decimal_carry_flag)
        core_u.issue(OP_CLEAR_CARRY, 16'h0000, 16'h0000);
        `CHK("clrcarry", 1'b0, decimal_carry_flag)
        $display("test addb done");
    endtask
    task automatic t_shift;
        wr_mant(1'b0, 48'h987654321098);
        core_u.issue(OP_OPERAND_RSHIFT, 16'h0007, 16'h0001);
        chk_m(1'b0, 48'h798765432109, "opshift");
        `CHK("a", 4'h8, core_u.reg_a[3:0])
        `CHK("carry", 1'b0, decimal_carry_flag)
        wr_mant(1'b1, 48'h123456789012);
        core_u.issue(OP_RESULT_RSHIFT, 16'h0005, 16'h0002);
        chk_m(1'b1, 48'h051234567890, "accshift");
        `CHK("a", 4'h1, core_u.reg_a[3:0])
        core_u.issue(OP_RESULT_RSHIFT, 16'h0009, 16'h0000);
        chk_m(1'b1, 48'h051234567890, "noshift");
        `CHK("a_kept", 4'h9, core_u.reg_a[3:0])
        $display("test shift done");
    endtask
    task automatic t_norm;
        wr_mant(1'b1, 48'h000012345678);
        core_u.issue(OP_NORMALIZE, 16'h0000, 16'h0000);
        chk_m(1'b1, 48'h123456780000, "norm");
        `CHK("count", 16'h0004, core_u.reg_b)
        `CHK("carry", 1'b0, decimal_carry_flag)
        wr_mant(1'b1, 48'h000000000000);
        core_u.issue(OP_NORMALIZE, 16'h0000, 16'h0000);
        `CHK("count", 16'h000c, core_u.reg_b)
        `CHK("carry", 1'b1, decimal_carry_flag)
        $display("test norm done");
    endtask
    task automatic t_cmp;
        wr_mant(1'b0, 48'h000000000000);
        core_u.issue(OP_COMPLEMENT_OPERAND, 16'h0000, 16'h0000);
        chk_m(1'b0, 48'h000000000000, "cmpzero");
        `CHK("carry", 1'b0, decimal_carry_flag)
        wr_mant(1'b1, 48'h000000000001);
        core_u.issue(OP_COMPLEMENT_RESULT, 16'h0000, 16'h0000);
        chk_m(1'b1, 48'h999999999999, "cmpres");
        $display("test complement done");
    endtask
    task automatic t_mul;
        wr_mant(1'b0, 48'h999999999999);
        wr_mant(1'b1, 48'h000000000000);
        core_u.issue(OP_FAST_MULTIPLY, 16'h0000, 16'h0009);
        chk_m(1'b1, 48'h999999999991, "product");
        `CHK("ovdigit", 4'h8, core_u.reg_a[3:0])
        core_u.issue(OP_FAST_MULTIPLY, 16'h000f, 16'h0000);
        chk_m(1'b1, 48'h999999999991, "mulzero");
        `CHK("ovdigit", 4'h0, core_u.reg_a[3:0])
        $display("test multiply done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (4000) @(posedge core_clk);
        err_total++;
        $display("[FAIL] watchdog exp done got timeout");
        close_out();
    end
    initial begin
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        chk_m(1'b1, 48'h000000000000, "reset");
        `CHK("carry", 1'b0, decimal_carry_flag)
        t_add();
        t_addb();
        t_shift();
        t_norm();
        t_cmp();
        t_mul();
        close_out();
    end
endmodule
bind bcd_mantissa_arith_unit bcd_arith_checker chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .op_start(op_start), .op_code(op_code), .b_in(b_in), .busy(busy), .op_done(op_done),
    .a_out(a_out), .a_write(a_write), .b_out(b_out), .b_write(b_write),
    .decimal_carry_flag(decimal_carry_flag));
